// File: iewc_chk_asserts.sv
// port checker for the nonvolatile write controller
// assumes one clock domain; bound onto every controller instance
`timescale 1ns/1ps
`default_nettype none
module iewc_chk
    import iewc_pkg::*;
#(
    parameter int TERM = PROG_CYCLES
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic mem_sel_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic [DATA_W-1:0] mem_data_o,
    input wire logic mem_ce_n_o,
    input wire logic mem_oe_n_o,
    input wire logic vpp_en_o,
    input wire logic xcvr_en_o,
    input wire logic xcvr_to_bus_o,
    input wire logic busy_o,
    input wire logic done_irq_o,
    input wire logic illegal_irq_o
);
    logic [CNT_W-1:0] vcnt;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // pulse length counter; too long for a repetition, so count it here
    // frozen cycles do not count, as the design holds its timer then
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) vcnt <= '0;
        else if (!vpp_en_o) vcnt <= '0;
        else if (ce_i) vcnt <= vcnt + CNT_W'(1);
    end
    AST_WR_START: assert property (ce_i && mem_sel_i && wr_i && !busy_o
        |=> vpp_en_o && !xcvr_en_o && busy_o) else $error("write not taken");
    AST_ISOLATE: assert property (vpp_en_o |-> !xcvr_en_o)
        else $error("transceiver on during pulse");
    AST_HOLD: assert property (vpp_en_o && $past(vpp_en_o)
        |-> $stable(mem_addr_o) && $stable(mem_data_o))
        else $error("latches moved during pulse");
    AST_ILLEGAL: assert property (busy_o && ce_i && mem_sel_i &&
        (wr_i || rd_i) |=> illegal_irq_o) else $error("no illegal irq");
    AST_EXPIRY: assert property ($fell(vpp_en_o) |-> !done_irq_o
        ##1 done_irq_o && xcvr_en_o && mem_ce_n_o)
        else $error("bad expiry order");
    AST_START_CLR: assert property ($rose(vpp_en_o) |-> !done_irq_o)
        else $error("done not cleared at start");
    AST_READ: assert property (!busy_o && ce_i && mem_sel_i && rd_i
        && !wr_i |=> !mem_ce_n_o && !mem_oe_n_o && xcvr_to_bus_o)
        else $error("read path not opened");
    AST_LEN: assert property ($fell(vpp_en_o)
        |-> vcnt == TERM + 1) else $error("pulse length wrong");
endmodule
bind iewc_ctrl iewc_chk #(.TERM(TERM)) u_chk (.clk_i(clk_i),
    .nrst_i(nrst_i), .ce_i(ce_i), .mem_sel_i(mem_sel_i), .wr_i(wr_i),
    .rd_i(rd_i), .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
    .mem_ce_n_o(mem_ce_n_o), .mem_oe_n_o(mem_oe_n_o),
    .vpp_en_o(vpp_en_o), .xcvr_en_o(xcvr_en_o),
    .xcvr_to_bus_o(xcvr_to_bus_o), .busy_o(busy_o),
    .done_irq_o(done_irq_o), .illegal_irq_o(illegal_irq_o));
`default_nettype wire

// File: iewc_cpu.sv
// processor bus model facing the write controller
// assumes strobes change only at falling clock edges
`timescale 1ns/1ps
`default_nettype none
module iewc_cpu
    import iewc_pkg::*;
(
    input wire logic clk_i,
    output logic sel_o,
    output logic wr_o,
    output logic rd_o,
    output logic ack_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] data_o
);
    initial begin
        {sel_o, wr_o, rd_o, ack_o} = '0;
        addr_o = '0;
        data_o = '0;
    end
    // one-cycle access; released lines show the inverse, not a held value
    task automatic cycle(input logic w, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d);
        @(negedge clk_i);
        {sel_o, wr_o, rd_o} = {1'b1, w, !w};
        addr_o = a;
        data_o = d;
        @(negedge clk_i);
        {sel_o, wr_o, rd_o} = '0;
        addr_o = ~a;
        data_o = ~d;
    endtask
    task automatic clear(input logic [ADDR_W-1:0] a);
        cycle(1'b1, a, 8'hFF);
    endtask
    task automatic ack();
        @(negedge clk_i);
        ack_o = 1'b1;
        @(negedge clk_i);
        ack_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: iewc_ctrl.sv
// write controller between a processor bus and a byte-erasable memory
// assumes bus strobes come from the same clock domain; the memory pins
// and the transceiver are outside, driven from the registered outputs
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - a memory write latches address and data, held through programming
// - a captured write disables the bus-to-memory data transceiver
// - timer starts only with write strobe and memory select together
// - programming-voltage enable stays high for the full 10 ms
// - timer start clears pending completion interrupt state
// - at expiry the programming-voltage enable drops first
// - after expiry transceiver and latches return to read path
// - a write-complete interrupt is raised in the same cycle as that return
// - any memory access during programming raises illegal-access interrupt
// - in read mode memory data pass through the transceiver, no waits
// - selection logic drives chip enable, output enable, latch, direction
module iewc_ctrl #(
    // timer terminal count in cycles, the pulse lasts one cycle more; only a bench shortens it below ten ms
    parameter int TERM = iewc_pkg::PROG_CYCLES
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic mem_sel_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [iewc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [iewc_pkg::DATA_W-1:0] data_i,
    input wire logic int_ack_i,
    output logic [iewc_pkg::ADDR_W-1:0] mem_addr_o,
    output logic [iewc_pkg::DATA_W-1:0] mem_data_o,
    output logic mem_data_oe_o,
    output logic mem_ce_n_o,
    output logic mem_oe_n_o,
    output logic vpp_en_o,
    output logic xcvr_en_o,
    output logic xcvr_to_bus_o,
    output logic busy_o,
    output logic done_irq_o,
    output logic illegal_irq_o
);
    import iewc_pkg::*;

    iewc_state_t state;
    iewc_state_t next_state;
    logic [ADDR_W-1:0] addr_hold;
    logic [ADDR_W-1:0] next_addr_hold;
    logic [DATA_W-1:0] data_hold;
    logic [DATA_W-1:0] next_data_hold;
    logic latch_on;
    logic next_latch_on;
    logic vpp;
    logic next_vpp;
    logic xcvr_en;
    logic next_xcvr_en;
    logic to_bus;
    logic next_to_bus;
    logic ce_n;
    logic next_ce_n;
    logic oe_n;
    logic next_oe_n;
    logic done_irq;
    logic next_done_irq;
    logic ill_irq;
    logic next_ill_irq;
    logic busy;
    logic next_busy;
    logic start;
    logic t_busy;
    logic t_expire;
    logic wr_hit;
    logic any_hit;

    // strobes and select meet at the selection logic
    // a read during programming counts as illegal just like a write
    assign wr_hit = mem_sel_i && wr_i;
    assign any_hit = mem_sel_i && (wr_i || rd_i);

    // cycle-counted pulse timer
    // programming interval timer
    iewc_timer #(
        .TERM(TERM)
    ) u_timer (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .start_i(start),
        .busy_o(t_busy),
        .expire_o(t_expire)
    );

    // mode sequencing, latches and selection outputs
    always_comb begin
        next_state = state;
        next_addr_hold = addr_hold;
        next_data_hold = data_hold;
        next_latch_on = latch_on;
        next_vpp = vpp;
        next_xcvr_en = xcvr_en;
        next_to_bus = to_bus;
        next_ce_n = ce_n;
        next_oe_n = oe_n;
        next_done_irq = done_irq;
        next_ill_irq = ill_irq;
        start = 1'b0;
        if (int_ack_i) begin
            next_done_irq = 1'b0;
            next_ill_irq = 1'b0;
        end
        case (state)
            IEWC_READ: begin
                next_ce_n = !(mem_sel_i && rd_i);
                next_oe_n = !(mem_sel_i && rd_i);
                next_xcvr_en = 1'b1;
                next_to_bus = 1'b1;
                if (wr_hit) begin
                    start = 1'b1;
                    next_state = IEWC_PROG;
                    next_addr_hold = addr_i;
                    next_data_hold = data_i;
                    next_latch_on = 1'b1;
                    next_xcvr_en = 1'b0;
                    // write select: ce low, oe high
                    next_ce_n = 1'b0;
                    next_oe_n = 1'b1;
                    next_to_bus = 1'b0;
                    next_vpp = 1'b1;
                    next_done_irq = 1'b0;
                    next_ill_irq = 1'b0;
                end
            end
            IEWC_PROG: begin
                if (any_hit) begin
                    next_ill_irq = 1'b1;
                end
                if (t_expire) begin
                    next_vpp = 1'b0;
                    next_state = IEWC_DONE;
                end
            end
            IEWC_DONE: begin
                next_latch_on = 1'b0;
                next_xcvr_en = 1'b1;
                next_to_bus = 1'b1;
                next_ce_n = 1'b1;
                next_oe_n = 1'b1;
                next_done_irq = 1'b1;
                if (any_hit) begin
                    next_ill_irq = 1'b1;
                end
                next_state = IEWC_READ;
            end
            default: begin
                next_state = IEWC_READ;
            end
        endcase
        // timer flag kept as a second witness should the state word upset
        next_busy = t_busy || (next_state != IEWC_READ);
    end

    // registers; the clock enable freezes everything
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= IEWC_READ;
            addr_hold <= ADDR_RESET;
            data_hold <= DATA_RESET;
            latch_on <= 1'b0;
            vpp <= 1'b0;
            xcvr_en <= 1'b1;
            to_bus <= 1'b1;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            done_irq <= 1'b0;
            ill_irq <= 1'b0;
            busy <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
            addr_hold <= next_addr_hold;
            data_hold <= next_data_hold;
            latch_on <= next_latch_on;
            vpp <= next_vpp;
            xcvr_en <= next_xcvr_en;
            to_bus <= next_to_bus;
            ce_n <= next_ce_n;
            oe_n <= next_oe_n;
            done_irq <= next_done_irq;
            ill_irq <= next_ill_irq;
            busy <= next_busy;
        end
    end

    // busy comes from a flip-flop so the bus side never sees a glitch
    assign busy_o = busy;
    assign mem_addr_o = addr_hold;
    assign mem_data_o = data_hold;
    assign mem_data_oe_o = latch_on;
    assign mem_ce_n_o = ce_n;
    assign mem_oe_n_o = oe_n;
    assign vpp_en_o = vpp;
    assign xcvr_en_o = xcvr_en;
    assign xcvr_to_bus_o = to_bus;
    assign done_irq_o = done_irq;
    assign illegal_irq_o = ill_irq;
endmodule
`default_nettype wire

// File: iewc_pkg.sv
// package for the interrupt-driven nonvolatile write controller
// assumes a 25 MHz system clock; holds timing and width constants
package iewc_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    // programming pulse length in microseconds and clock rate in kHz
    localparam int PROG_TIME_US = 10000;
    localparam int CLK_KHZ = 25000;
    // least time rounds up to whole cycles
    localparam int PROG_CYCLES = (PROG_TIME_US * CLK_KHZ + 999) / 1000;
    localparam int CNT_W = 18;
    localparam logic [CNT_W-1:0] CNT_RESET = 18'h00000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 11'h000;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    // controller modes
    typedef enum logic [1:0] {
        IEWC_READ = 2'b00,
        IEWC_PROG = 2'b01,
        IEWC_DONE = 2'b11
    } iewc_state_t;
endpackage

// File: iewc_timer.sv
// programming pulse timer: counts cycles from a start pulse to terminal count
// assumes start arrives only while idle; same clock as the controller
`timescale 1ns/1ps
`default_nettype none
module iewc_timer #(
    parameter int TERM = iewc_pkg::PROG_CYCLES
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic start_i,
    output logic busy_o,
    output logic expire_o
);
    import iewc_pkg::*;

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic busy;
    logic next_busy;
    logic expire;
    logic next_expire;

    // a running timer ignores further starts, so the pulse is never stretched
    always_comb begin
        next_count = count;
        next_busy = busy;
        next_expire = 1'b0;
        if (!busy && start_i) begin
            next_busy = 1'b1;
            next_count = CNT_RESET;
        end else if (busy) begin
            if (count == CNT_W'(TERM - 1)) begin
                next_busy = 1'b0;
                next_expire = 1'b1;
            end else begin
                next_count = count + 18'h00001;
            end
        end
    end

    // state registers, frozen while the clock enable is low
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count <= CNT_RESET;
            busy <= 1'b0;
            expire <= 1'b0;
        end else if (ce_i) begin
            count <= next_count;
            busy <= next_busy;
            expire <= next_expire;
        end
    end

    assign busy_o = busy;
    assign expire_o = expire;
endmodule
`default_nettype wire

// File: test_interrupt_driven_eeprom_write_ctrl.sv
// testbench for the write controller with a processor bus model
// assumes a shortened pulse count so several writes fit in the run
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_driven_eeprom_write_ctrl;
    import iewc_pkg::*;
    logic clk_i = 0, nrst_i = 0, ce_i = 1;
    logic mem_sel_i, wr_i, rd_i, int_ack_i, mem_data_oe_o;
    logic [ADDR_W-1:0] addr_i, mem_addr_o;
    logic [DATA_W-1:0] data_i, mem_data_o;
    logic mem_ce_n_o, mem_oe_n_o, vpp_en_o, xcvr_en_o;
    logic xcvr_to_bus_o, busy_o, done_irq_o, illegal_irq_o;
    int miscompares = 0, n_checks = 0, n = 0;
    // a full ten ms pulse would take far too long to simulate
    localparam int SIM_TERM = 40;
    always #20 clk_i = ~clk_i;
    iewc_ctrl #(.TERM(SIM_TERM)) uut (.clk_i(clk_i), .nrst_i(nrst_i),
        .ce_i(ce_i), .mem_sel_i(mem_sel_i), .wr_i(wr_i), .rd_i(rd_i),
        .addr_i(addr_i), .data_i(data_i), .int_ack_i(int_ack_i),
        .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
        .mem_data_oe_o(mem_data_oe_o), .mem_ce_n_o(mem_ce_n_o),
        .mem_oe_n_o(mem_oe_n_o), .vpp_en_o(vpp_en_o),
        .xcvr_en_o(xcvr_en_o), .xcvr_to_bus_o(xcvr_to_bus_o),
        .busy_o(busy_o), .done_irq_o(done_irq_o),
        .illegal_irq_o(illegal_irq_o));
    iewc_cpu cpu (.clk_i(clk_i), .sel_o(mem_sel_i), .wr_o(wr_i),
        .rd_o(rd_i), .ack_o(int_ack_i), .addr_o(addr_i), .data_o(data_i));
    // pulse cycles seen by the bench, independent of the checker
    always @(negedge clk_i) if (vpp_en_o === 1'b1) n++;
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // waits for the completion flag, bounded so a hang still ends
    task automatic wait_done();
        int k;
        k = 0;
        while (done_irq_o !== 1'b1 && k < 2 * SIM_TERM + 20) begin
            @(negedge clk_i);
            k++;
        end
    endtask
    task automatic t_reset();
        repeat (8) @(negedge clk_i);
        chk("vpp", 0, vpp_en_o);
        chk("xcvr", 1, xcvr_en_o);
        chk("irqs", 0, {done_irq_o, illegal_irq_o, busy_o});
        nrst_i = 1;
        $display("test reset done");
    endtask
    task automatic t_read();
        cpu.cycle(1'b0, 11'h155, 8'h00);
        chk("ce oe", 0, {mem_ce_n_o, mem_oe_n_o});
        chk("dir", 3, {xcvr_en_o, xcvr_to_bus_o});
        $display("test read done");
    endtask
    task automatic t_write();
        cpu.clear(11'h7FF);
        chk("start", 3, {vpp_en_o, busy_o});
        chk("xcvr", 0, xcvr_en_o);
        chk("latch", {11'h7FF, 8'hFF}, {mem_addr_o, mem_data_o});
        cpu.cycle(1'b1, 11'h001, 8'h5A);
        chk("illegal", 1, illegal_irq_o);
        chk("latch", {11'h7FF, 8'hFF}, {mem_addr_o, mem_data_o});
        cpu.ack();
        chk("ack ill", 0, illegal_irq_o);
        cpu.cycle(1'b0, 11'h002, 8'h00);
        chk("illegal", 1, illegal_irq_o);
        wait_done();
        chk("pulse", SIM_TERM + 1, n);
        chk("end", 2'b01, {vpp_en_o, done_irq_o});
        chk("back", 3, {xcvr_en_o, mem_ce_n_o});
        cpu.ack();
        chk("ack", 0, {done_irq_o, illegal_irq_o});
        $display("test write done");
    endtask
    // data write after the clear, clock held for five cycles mid-pulse,
    // then a new write while completion is still pending
    task automatic t_update();
        n = 0;
        cpu.cycle(1'b1, 11'h7FF, 8'h5A);
        chk("drive", 3'b101, {mem_data_oe_o, mem_ce_n_o, mem_oe_n_o});
        chk("dir", 0, xcvr_to_bus_o);
        ce_i = 0;
        repeat (5) @(negedge clk_i);
        chk("frozen", 3, {vpp_en_o, busy_o});
        ce_i = 1;
        wait_done();
        chk("pulse", SIM_TERM + 6, n);
        chk("latch", {11'h7FF, 8'h5A}, {mem_addr_o, mem_data_o});
        chk("path", 3'b011, {mem_data_oe_o, xcvr_en_o, xcvr_to_bus_o});
        cpu.clear(11'h001);
        chk("start clr", 0, done_irq_o);
        wait_done();
        chk("done", 3'b100, {done_irq_o, illegal_irq_o, busy_o});
        cpu.ack();
        chk("ack", 0, done_irq_o);
        $display("test update done");
    endtask
    initial begin
        t_reset();
        t_read();
        t_write();
        t_update();
        conclude();
    end
    initial begin
        #(40ns * (4 * SIM_TERM + 400));
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire
